// ### common/uod_pkg.sv
// Package for the OUT endpoint descriptor block: register map, bit
// positions, reset values, link handshake codes and the state record.
// Assumes one clock domain and a byte-wide firmware register port.
package uod_pkg;

  // Register port and memory widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int RAM_AW = 11;
  localparam int EP_NUM = 3;

  // Descriptor map: endpoint n config at EP1_BASE + (n-1) * stride
  localparam logic [15:0] EP1_BASE  = 16'hFF08;
  localparam logic [15:0] EP2_BASE  = 16'hFF10;
  localparam logic [15:0] EP3_BASE  = 16'hFF18;
  localparam logic [2:0]  OFS_CFG   = 3'h0;
  localparam logic [2:0]  OFS_XBASE = 3'h1;
  localparam logic [2:0]  OFS_STAT  = 3'h3;

  // Config byte fields
  localparam int CFG_ENABLE_BIT = 7;
  localparam int CFG_ISO_BIT    = 6;
  localparam int CFG_TOGGLE_BIT = 5;
  localparam int CFG_DOUBLE_BUFFER_ENABLE_BIT   = 4;
  localparam int CFG_STALL_BIT  = 3;
  localparam int CFG_IE_BIT     = 2;

  // Status byte fields (write one to clear)
  localparam int STAT_XFULL_BIT = 7;
  localparam int STAT_YFULL_BIT = 6;

  // Reset values
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [7:0] XBASE_RESET = 8'h00;

  // Buffer geometry
  localparam int          BASE_LSB_ZEROS = 3;
  localparam logic [6:0]  MAX_PKT        = 7'h40;
  localparam logic [10:0] Y_BUF_OFS      = 11'h040;

  typedef enum logic [1:0] {
    HS_NONE,
    HS_ACK,
    HS_NAK,
    HS_STALL
  } uod_hs_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RECV,
    ST_DROP,
    ST_DRAIN
  } uod_rx_state_type;

  typedef struct packed {
    logic [RAM_AW-1:0] addr;
    logic [7:0]        data;
  } uod_mem_wr_type;

  typedef struct packed {
    logic [2:0][7:0]       cfg;
    logic [2:0][7:0]       xbase;
    logic [2:0]            xfull;
    logic [2:0]            yfull;
    uod_rx_state_type      st;
    logic [1:0]            idx;
    logic                  ybuf;
    logic                  keep;
    logic [6:0]            cnt;
    uod_hs_type            pend;
    uod_mem_wr_type [1:0]  fifo;
    logic [1:0]            fcnt;
    logic                  rd_ptr;
    logic                  wr_ptr;
    logic                  rx_ready;
    uod_mem_wr_type        mem;
    logic                  mem_valid;
    logic [7:0]            rdata;
    logic                  hs_valid;
    uod_hs_type            hs;
    logic                  irq;
    logic [1:0]            irq_ep;
  } uod_state_type;

endpackage

// ### hw/uod_out_endpoint.sv
// OUT endpoint 1..3 descriptor registers and the packet receive path
// that stores host OUT data into buffer RAM.
// Assumes link and RAM port logic run on mclk_in; no synchronisers needed.
`timescale 1ns/1ps

// Function
// - Config byte per endpoint at fixed bases
// - Bit 7 gates buffer manager service
// - Bit 3 set answers STALL until cleared
// - Bit 2 enables completion interrupt request
// - X base at offset 1, fully read/write
// - X start address is base byte plus 000; Y start adds 040
// - Data written from programmed start address
// - Hardware never alters X base entry
// - Full buffer answers NAK, empty receives when data toggle matches
module uod_out_endpoint
  import uod_pkg::*;
(
  // Clock and reset
  input  wire logic                mclk_in,
  input  wire logic                arst_n_in,
  // Firmware register port
  input  wire logic [ADDR_W-1:0]   reg_addr_in,
  input  wire logic [DATA_W-1:0]   reg_wdata_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  output logic      [DATA_W-1:0]   reg_rdata_out,
  // Link packet framing
  input  wire logic                pkt_start_in,
  input  wire logic [1:0]          pkt_ep_in,
  input  wire logic                pkt_data1_in,
  input  wire logic                pkt_end_in,
  input  wire logic                pkt_ok_in,
  // Link byte stream
  input  wire logic                rx_valid_in,
  input  wire logic [7:0]          rx_data_in,
  output logic                     rx_ready_out,
  // Handshake answer to the host
  output logic                     hs_valid_out,
  output uod_hs_type               hs_code_out,
  // Buffer RAM write port
  output logic                     mem_valid_out,
  output logic      [RAM_AW-1:0]   mem_addr_out,
  output logic      [7:0]          mem_data_out,
  input  wire logic                mem_ready_in,
  // Completion request
  output logic                     irq_req_out,
  output logic      [1:0]          irq_ep_out
);

  uod_state_type s_ff;
  uod_state_type nxt_s;

  // Register address decode: hit, endpoint index, offset
  function automatic logic [5:0] decode(input logic [ADDR_W-1:0] a);
    logic [1:0] ep;
    ep = a[4:3];
    decode = {(a[15:5] == EP1_BASE[15:5]) && (ep != 2'd0), 2'(ep - 2'd1), a[2:0]};
  endfunction

  // Start of the selected buffer within RAM
  function automatic logic [RAM_AW-1:0] buf_start(input logic [7:0] xb, input logic yb);
    logic [RAM_AW-1:0] x;
    x = {xb, {BASE_LSB_ZEROS{1'b0}}};
    buf_start = yb ? RAM_AW'(x + Y_BUF_OFS) : x;
  endfunction

  always_comb
  begin
    logic [5:0]        dec;
    logic [1:0]        i;
    logic [7:0]        c;
    logic              yb;
    logic              full;
    logic              pop;
    logic              push;
    uod_mem_wr_type    w;
    dec  = 6'h00;
    i    = 2'd0;
    c    = 8'h00;
    yb   = 1'b0;
    full = 1'b0;
    pop  = 1'b0;
    push = 1'b0;
    w    = '0;
    nxt_s          = s_ff;
    nxt_s.hs_valid = 1'b0;
    nxt_s.hs       = HS_NONE;
    nxt_s.irq      = 1'b0;

    // Firmware writes; hardware updates below take priority
    dec = decode(reg_addr_in);
    if (reg_wr_in && dec[5])
    begin
      case (dec[2:0])
        OFS_CFG:   nxt_s.cfg[dec[4:3]] = reg_wdata_in;
        OFS_XBASE: nxt_s.xbase[dec[4:3]] = reg_wdata_in;
        OFS_STAT:
        begin
          if (reg_wdata_in[STAT_XFULL_BIT])
            nxt_s.xfull[dec[4:3]] = 1'b0;
          if (reg_wdata_in[STAT_YFULL_BIT])
            nxt_s.yfull[dec[4:3]] = 1'b0;
        end
        default: ;
      endcase
    end

    // Reads answer one cycle later; unmapped reads give zero
    nxt_s.rdata = 8'h00;
    if (reg_rd_in && dec[5])
    begin
      case (dec[2:0])
        OFS_CFG:   nxt_s.rdata = s_ff.cfg[dec[4:3]];
        OFS_XBASE: nxt_s.rdata = s_ff.xbase[dec[4:3]];
        OFS_STAT:
        begin
          nxt_s.rdata[STAT_XFULL_BIT] = s_ff.xfull[dec[4:3]];
          nxt_s.rdata[STAT_YFULL_BIT] = s_ff.yfull[dec[4:3]];
        end
        default: nxt_s.rdata = 8'h00;
      endcase
    end

    // RAM output stage, refilled from the two-entry buffer
    if (s_ff.mem_valid && mem_ready_in)
      nxt_s.mem_valid = 1'b0;
    if ((s_ff.fcnt != 2'd0) && !nxt_s.mem_valid)
    begin
      pop             = 1'b1;
      nxt_s.mem       = s_ff.fifo[s_ff.rd_ptr];
      nxt_s.mem_valid = 1'b1;
      nxt_s.rd_ptr    = ~s_ff.rd_ptr;
    end

    // Byte intake while receiving
    if (s_ff.st == ST_RECV && rx_valid_in && s_ff.rx_ready)
    begin
      if (s_ff.cnt < MAX_PKT)
      begin
        push   = 1'b1;
        w.addr = RAM_AW'(buf_start(s_ff.xbase[s_ff.idx], s_ff.ybuf)
                         + RAM_AW'(s_ff.cnt));
        w.data = rx_data_in;
        nxt_s.fifo[s_ff.wr_ptr] = w;
        nxt_s.wr_ptr = ~s_ff.wr_ptr;
        nxt_s.cnt    = 7'(s_ff.cnt + 7'd1);
      end
      else
        nxt_s.keep = 1'b0;
    end
    nxt_s.fcnt = 2'(s_ff.fcnt + {1'b0, push} - {1'b0, pop});

    case (s_ff.st)
      ST_IDLE:
      begin
        if (pkt_start_in)
        begin
          // Endpoint zero is not ours; keep the index inside the table
          i    = (pkt_ep_in == 2'd0) ? 2'd0 : 2'(pkt_ep_in - 2'd1);
          c    = s_ff.cfg[i];
          yb   = c[CFG_DOUBLE_BUFFER_ENABLE_BIT] & c[CFG_TOGGLE_BIT];
          full = yb ? s_ff.yfull[i] : s_ff.xfull[i];
          nxt_s.idx  = i;
          nxt_s.ybuf = yb;
          nxt_s.cnt  = 7'd0;
          nxt_s.keep = 1'b1;
          nxt_s.st   = ST_DROP;
          if (pkt_ep_in == 2'd0)
            nxt_s.pend = HS_NONE;
          else if (c[CFG_STALL_BIT])
            nxt_s.pend = HS_STALL;
          else if (!c[CFG_ENABLE_BIT])
            nxt_s.pend = HS_NAK;
          else if (full)
            nxt_s.pend = HS_NAK;
          else if (pkt_data1_in != c[CFG_TOGGLE_BIT])
            nxt_s.pend = HS_ACK;
          else
          begin
            nxt_s.pend = HS_ACK;
            nxt_s.st   = ST_RECV;
          end
        end
      end
      ST_RECV:
      begin
        if (pkt_end_in)
        begin
          nxt_s.keep = nxt_s.keep & pkt_ok_in;
          nxt_s.st   = ST_DRAIN;
        end
      end
      ST_DROP:
      begin
        if (pkt_end_in)
        begin
          nxt_s.hs_valid = pkt_ok_in && (s_ff.pend != HS_NONE);
          nxt_s.hs       = pkt_ok_in ? s_ff.pend : HS_NONE;
          nxt_s.st       = ST_IDLE;
        end
      end
      ST_DRAIN:
      begin
        // Completion only after every byte reached RAM
        if (s_ff.fcnt == 2'd0 && !s_ff.mem_valid)
        begin
          nxt_s.st = ST_IDLE;
          if (s_ff.keep)
          begin
            if (s_ff.ybuf)
              nxt_s.yfull[s_ff.idx] = 1'b1;
            else
              nxt_s.xfull[s_ff.idx] = 1'b1;
            nxt_s.cfg[s_ff.idx][CFG_TOGGLE_BIT] =
              ~s_ff.cfg[s_ff.idx][CFG_TOGGLE_BIT];
            nxt_s.hs_valid = 1'b1;
            nxt_s.hs       = HS_ACK;
            nxt_s.irq      = s_ff.cfg[s_ff.idx][CFG_IE_BIT];
            nxt_s.irq_ep   = 2'(s_ff.idx + 2'd1);
            // X base entry deliberately left untouched
          end
        end
      end
      default: nxt_s.st = ST_IDLE;
    endcase

    nxt_s.rx_ready = (nxt_s.st == ST_DROP) ||
                     ((nxt_s.st == ST_RECV) && (nxt_s.fcnt != 2'd2));
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_ff       <= '0;
      s_ff.cfg   <= {EP_NUM{CFG_RESET}};
      s_ff.xbase <= {EP_NUM{XBASE_RESET}};
      s_ff.st    <= ST_IDLE;
      s_ff.pend  <= HS_NONE;
      s_ff.hs    <= HS_NONE;
    end
    else
      s_ff <= nxt_s;
  end

  assign reg_rdata_out = s_ff.rdata;
  assign rx_ready_out  = s_ff.rx_ready;
  assign hs_valid_out  = s_ff.hs_valid;
  assign hs_code_out   = s_ff.hs;
  assign mem_valid_out = s_ff.mem_valid;
  assign mem_addr_out  = s_ff.mem.addr;
  assign mem_data_out  = s_ff.mem.data;
  assign irq_req_out   = s_ff.irq;
  assign irq_ep_out    = s_ff.irq_ep;

endmodule // uod_out_endpoint

// ### verification/uod_out_endpoint_assertions.sv
// Port checker for the OUT endpoint block.
// Assumes one clock and active-low reset.
`timescale 1ns/1ps
module uod_out_endpoint_assertions
  import uod_pkg::*;
(
  // Clock and reset
  input wire logic              mclk_in,
  input wire logic              arst_n_in,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  // Link and RAM
  input wire logic              rx_ready_out,
  input wire logic              hs_valid_out,
  input wire uod_hs_type        hs_code_out,
  input wire logic              mem_valid_out,
  input wire logic [RAM_AW-1:0] mem_addr_out,
  input wire logic [7:0]        mem_data_out,
  input wire logic              mem_ready_in,
  input wire logic              irq_req_out,
  input wire logic [1:0]        irq_ep_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  a_rdata_idle_zero: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not zero");
  a_unmapped_read: assert property (reg_rd_in && reg_addr_in == 16'h0000
    |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  a_xbase_write_read: assert property (reg_wr_in && reg_addr_in == EP1_BASE + 16'h0001
    ##1 reg_rd_in && reg_addr_in == EP1_BASE + 16'h0001
    |=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("base readback wrong");
  a_hs_one_pulse: assert property (hs_valid_out |=> !hs_valid_out)
    else $error("handshake longer than a cycle");
  a_irq_with_ack: assert property (irq_req_out |-> hs_valid_out && hs_code_out == HS_ACK)
    else $error("request without ack");
  a_ready_idle_low: assert property (hs_valid_out |-> !rx_ready_out)
    else $error("link ready after handshake");
  a_irq_one_pulse: assert property (irq_req_out |=> !irq_req_out)
    else $error("request longer than a cycle");
  a_irq_ep_range: assert property (irq_req_out |-> irq_ep_out != 2'h0)
    else $error("request for endpoint zero");
  a_mem_hold_stall: assert property (mem_valid_out && !mem_ready_in
    |=> mem_valid_out && $stable(mem_addr_out) && $stable(mem_data_out))
    else $error("ram write dropped in stall");
  c_stall: cover property (hs_valid_out && hs_code_out == HS_STALL);
  c_nak: cover property (hs_valid_out && hs_code_out == HS_NAK);
  c_irq: cover property (irq_req_out);
endmodule // uod_out_endpoint_assertions

bind uod_out_endpoint uod_out_endpoint_assertions chk_u (.mclk_in, .arst_n_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .rx_ready_out,
  .hs_valid_out,
  .hs_code_out, .mem_valid_out, .mem_addr_out, .mem_data_out, .mem_ready_in,
  .irq_req_out, .irq_ep_out);

// ### verification/uod_host_model.sv
// Host side: sends OUT transactions as framing pulses and a byte stream.
// Assumes the caller starts each send just after a rising edge.
`timescale 1ns/1ps
module uod_host_model
(
  // Clock
  input  wire logic  mclk_in,
  // Framing
  output logic       pkt_start_out,
  output logic [1:0] pkt_ep_out,
  output logic       pkt_data1_out,
  output logic       pkt_end_out,
  // Byte stream
  output logic       rx_valid_out,
  output logic [7:0] rx_data_out,
  input  wire logic  rx_ready_in
);
  initial
  begin
    {pkt_start_out, pkt_ep_out, pkt_data1_out, pkt_end_out, rx_valid_out} = '0;
    rx_data_out = 8'h00;
  end

  // Bytes run upward from seed; valid held until taken
  task automatic send(input logic [1:0] ep, input logic d1, input int n, input logic [7:0] s);
    pkt_start_out <= 1'b1;
    pkt_ep_out    <= ep;
    pkt_data1_out <= d1;
    @(posedge mclk_in);
    pkt_start_out <= 1'b0;
    rx_valid_out  <= 1'b1;
    for (int k = 0; k < n; k++)
    begin
      rx_data_out <= s + 8'(k);
      @(posedge mclk_in);
      while (!rx_ready_in)
        @(posedge mclk_in);
    end
    rx_valid_out <= 1'b0;
    rx_data_out  <= ~(s + 8'(n - 1));
    pkt_end_out  <= 1'b1;
    @(posedge mclk_in);
    pkt_end_out <= 1'b0;
  endtask
endmodule // uod_host_model

// ### verification/uod_out_endpoint_tb.sv
// Bench for the OUT endpoint block: register calls and host packets.
// Assumes the host model and the checker bound to the design.
`timescale 1ns/1ps
module uod_out_endpoint_tb;
  import uod_pkg::*;
  logic mclk_in = 1'b0, arst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [15:0] reg_addr_in = '0, a0;
  logic [7:0] reg_wdata_in = '0, reg_rdata_out, rx_data, mem_data_out;
  logic pkt_start, pkt_d1, pkt_end, rx_valid, rx_ready_out, hs_valid_out, mem_valid_out;
  logic mem_ready_in = 1'b0, irq_req_out;
  logic [1:0] pkt_ep, irq_ep_out;
  logic [10:0] mem_addr_out;
  uod_hs_type hs_code_out;
  int n_errors = 0, num_checks = 0, nw = 0, nw0 = 0, cyc = 0;

  always #2.5 mclk_in = ~mclk_in;

  uod_out_endpoint dut_u (.mclk_in, .arst_n_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .pkt_start_in(pkt_start),
    .pkt_ep_in(pkt_ep), .pkt_data1_in(pkt_d1), .pkt_end_in(pkt_end), .pkt_ok_in(1'b1),
    .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_ready_out, .hs_valid_out, .hs_code_out,
    .mem_valid_out, .mem_addr_out, .mem_data_out, .mem_ready_in, .irq_req_out, .irq_ep_out);
  uod_host_model host_u (.mclk_in, .pkt_start_out(pkt_start), .pkt_ep_out(pkt_ep),
    .pkt_data1_out(pkt_d1), .pkt_end_out(pkt_end), .rx_valid_out(rx_valid),
    .rx_data_out(rx_data), .rx_ready_in(rx_ready_out));

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 chk(16'(reg_rdata_out), 16'(e));
    @(posedge mclk_in);
  endtask

  // Stalling RAM: ready four cycles of eight
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    mem_ready_in <= cyc[2];
    if (mem_valid_out === 1'b1 && mem_ready_in === 1'b1)
    begin
      chk(16'(mem_addr_out), a0 + 16'(nw - nw0));
      chk(16'(mem_data_out), 16'h0030 + 16'(nw - nw0));
      nw++;
    end
    if (cyc == 20000)
    begin
      n_errors++;
      test_done;
    end
  end

  task automatic pkt(input logic [1:0] ep, input logic d1, input int n, input uod_hs_type c,
                     input logic irq, input logic [15:0] a, input int m);
    int w;
    nw0 = nw;
    a0 = a;
    w = 0;
    host_u.send(ep, d1, n, 8'h30);
    do
    begin
      @(posedge mclk_in);
      w++;
    end
    while (hs_valid_out !== 1'b1 && w < 200);
    chk(16'(hs_valid_out), 16'h0001);
    chk(16'(hs_code_out), 16'(c));
    chk(16'(irq_req_out), 16'(irq));
    if (irq)
      chk(16'(irq_ep_out), 16'(ep));
    chk(16'(nw - nw0), 16'(m));
  endtask

  initial
  begin
    repeat (4) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    @(posedge mclk_in);
    for (int n = 0; n < 3; n++)
    begin
      rd(EP1_BASE + 16'(8 * n), CFG_RESET);
      rd(EP1_BASE + 16'(8 * n + 1), XBASE_RESET);
      wr(EP1_BASE + 16'(8 * n + 1), 8'h12 + 8'(n));
      rd(EP1_BASE + 16'(8 * n + 1), 8'h12 + 8'(n));
    end
    rd(16'h0000, 8'h00);
    wr(EP1_BASE, 8'h84);
    pkt(2'h1, 1'b0, 3, HS_ACK, 1'b1, 16'h0090, 3);
    rd(EP1_BASE, 8'hA4);
    rd(EP1_BASE + 16'h0001, 8'h12);
    rd(EP1_BASE + 16'h0003, 8'h80);
    pkt(2'h1, 1'b1, 2, HS_NAK, 1'b0, 16'h0000, 0);
    wr(EP1_BASE + 16'h0003, 8'h80);
    wr(EP1_BASE, 8'hB0);
    pkt(2'h1, 1'b1, 4, HS_ACK, 1'b0, 16'h00D0, 4);
    rd(EP1_BASE + 16'h0003, 8'h40);
    wr(EP2_BASE, 8'h88);
    pkt(2'h2, 1'b0, 1, HS_STALL, 1'b0, 16'h0000, 0);
    wr(EP2_BASE, 8'h80);
    pkt(2'h2, 1'b0, 2, HS_ACK, 1'b0, 16'h0098, 2);
    wr(EP2_BASE + 16'h0003, 8'h80);
    pkt(2'h2, 1'b0, 2, HS_ACK, 1'b0, 16'h0000, 0);
    rd(EP2_BASE, 8'hA0);
    pkt(2'h3, 1'b0, 1, HS_NAK, 1'b0, 16'h0000, 0);
    test_done;
  end
endmodule // uod_out_endpoint_tb
